// file: rtl/pew_host.sv
// Host controller driving a paged byte-wide EEPROM through its pins
// Overview of operation
// RL1: Write only with select low, enable high
// RL2: Device drives data only in read mode
// RL3: Read: address, then select, enable; write high
// RL4: Device latches transparent during read
// RL5: Address on later fall, data earliest rise
// RL6: Write pulse held at least minimum width
// RL7: One to 64 bytes per page load
// RL8: Row bits latched on first byte only
// RL9: Column bits latched on every byte
// RL10: Rising edge latches data, starts load timer
// RL11: Window expiry starts internal write, 10 ms
// RL12: Holding write low extends page load
// RL13: Device erases before programming automatically
// RL14: Busy read returns inverted last byte
// RL15: Polling during page load returns inverse
// RL16: Polling read uses normal read timing
// RL17: Poll until last byte reads true
// RL18: Completion line low from write start
// RL19: Completion line is open drain
// RL20: Power-up lockout until fresh write fall
// RL21: Optional chip erase with elevated enable
// RL22: Byte loads spaced 0.2 us, window 200 us
// RL23: Write pulses under 20 ns are noise
// RL24: Timeouts are counters from clock period
// RL25: Select-controlled writes mirror enable-controlled
module pew_host #(
   parameter int BLC_MAX_CYC = pew_pkg::BLC_MAX_CYC,
   parameter int WC_CYC      = pew_pkg::WC_CYC
) (
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire pew_pkg::pew_req_t           req,
   input  wire logic                        req_last,
   output logic                             rsp_valid,
   output logic [pew_pkg::DATA_W-1:0]       rsp_data,
   output logic                             busy,
   output logic                             poll_timeout,
   output pew_pkg::pew_bus_t                mem_bus,
   output logic [pew_pkg::DATA_W-1:0]       mem_data_out,
   output logic                             mem_data_oe_n,
   input  wire logic [pew_pkg::DATA_W-1:0]  mem_data_in,
   input  wire logic                        mem_ready_in
);
   // ==========================================================
   // State
   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_WR_LOW, ST_WR_GAP, ST_POLL, ST_POLL_GAP
   } pew_state_t;

   pew_state_t                    state;
   pew_state_t                    next_state;
   logic [pew_pkg::CNT_W-1:0]     cnt;
   logic [pew_pkg::CNT_W-1:0]     wait_cnt;
   logic [pew_pkg::ADDR_W-1:0]    last_addr;
   logic [pew_pkg::DATA_W-1:0]    last_data;
   logic [6:0]                    page_cnt;
   logic [pew_pkg::ADDR_W-1:0]    addr;
   logic [pew_pkg::DATA_W-1:0]    wdata;
   logic                          sel_n;
   logic                          oe_n;
   logic                          we_n;
   logic [pew_pkg::DATA_W-1:0]    data_sync;
   logic                          ready_sync;

   localparam logic [pew_pkg::CNT_W-1:0] WP_C =
      pew_pkg::CNT_W'(pew_pkg::WP_CYC);
   localparam logic [pew_pkg::CNT_W-1:0] GAP_C =
      pew_pkg::CNT_W'(pew_pkg::BLC_MIN_CYC);
   localparam logic [pew_pkg::CNT_W-1:0] ACC_C =
      pew_pkg::CNT_W'(pew_pkg::ACC_CYC + 3);
   localparam logic [pew_pkg::CNT_W-1:0] WC_C =
      pew_pkg::CNT_W'(WC_CYC + BLC_MAX_CYC);
   localparam logic [6:0] PAGE_C = 7'(pew_pkg::PAGE_BYTES);

   // ==========================================================
   // Pin input synchronisers
   pew_sync #(.W(pew_pkg::DATA_W + 1),
              .INIT({1'b1, {pew_pkg::DATA_W{1'b0}}})) u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .din     ({mem_ready_in, mem_data_in}),
      .dout    ({ready_sync, data_sync})
   );

   // ==========================================================
   // Decode
   wire cnt_done   = (cnt == '0);
   wire same_page  = (req.addr[pew_pkg::ADDR_W-1:pew_pkg::COL_W] ==
                      last_addr[pew_pkg::ADDR_W-1:pew_pkg::COL_W]);
   wire page_full  = (page_cnt == PAGE_C);
   wire loading    = (state == ST_WR_GAP);
   // Next write joins the page only on the same row while the page is not full
   wire join_ok    = req.wr && same_page && !page_full;   // see RL7 RL8
   wire poll_match = (data_sync == last_data);             // see RL17
   wire wait_over  = (wait_cnt == '0);
   wire take_idle  = (state == ST_IDLE) && req_valid;
   wire take_gap   = loading && cnt_done && req_valid && join_ok;
   // Strobe stays low until a next byte or the page end is known
   wire hold_done  = req_valid || req_last || page_full;   // see RL12
   assign req_ready = take_idle || take_gap;
   assign busy      = (state != ST_IDLE) && (state != ST_RD);
   // Address moves one cycle ahead of any control falling
   wire addr_moves = (req_ready && req_valid) ||
                     (loading && (next_state == ST_POLL));  // see RL3

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_state = req.wr ? ST_WR_LOW : ST_RD;
            end
         end
         ST_RD: begin
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_WR_LOW: begin
            if (cnt_done && hold_done) begin
               next_state = ST_WR_GAP;                 // see RL12
            end
         end
         ST_WR_GAP: begin
            if (take_gap) begin
               next_state = ST_WR_LOW;
            end else if (cnt_done && (req_last || page_full ||
                         (req_valid && !join_ok))) begin
               next_state = ST_POLL;                   // see RL11
            end
         end
         ST_POLL: begin
            if (cnt_done) begin
               next_state = ST_POLL_GAP;
            end
         end
         ST_POLL_GAP: begin
            if (poll_match && ready_sync) begin
               next_state = ST_IDLE;                   // see RL17
            end else if (wait_over) begin
               next_state = ST_IDLE;
            end else begin
               next_state = ST_POLL;
            end
         end
      endcase
   end

   // ==========================================================
   // Sequencer and pins
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt   <= '0;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            unique case (next_state)
               ST_RD, ST_POLL: cnt <= ACC_C;           // see RL16
               ST_WR_LOW:      cnt <= WP_C;            // see RL6 RL23
               ST_WR_GAP:      cnt <= GAP_C;           // see RL22
               default:        cnt <= '0;
            endcase
         end else if (!cnt_done) begin
            cnt <= cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wait_cnt <= '0;
      end else if (state == ST_WR_GAP && next_state == ST_POLL) begin
         wait_cnt <= WC_C;                             // see RL24
      end else if (!wait_over) begin
         wait_cnt <= wait_cnt - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         last_addr <= '0;
         last_data <= '0;
         page_cnt  <= '0;
      end else if (req_ready && req_valid && req.wr) begin
         last_addr <= req.addr;                        // see RL9
         last_data <= req.data;
         page_cnt  <= take_idle ? 7'd1 : page_cnt + 7'd1;
      end
   end

   // Address stable before select falls, write high whole read
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         addr  <= '0;
         wdata <= '0;
         sel_n <= 1'b1;
         oe_n  <= 1'b1;
         we_n  <= 1'b1;
      end else begin
         if (req_ready && req_valid) begin
            addr  <= req.addr;
            wdata <= req.data;
         end else if (next_state == ST_POLL) begin
            addr  <= last_addr;
         end
         // Write mode: select low, enable high, write low
         sel_n <= addr_moves || (next_state == ST_IDLE) ||
                  (loading && (next_state == ST_WR_GAP)); // see RL1 RL3
         oe_n  <= addr_moves || !((next_state == ST_RD) ||
                  (next_state == ST_POLL));              // see RL3 RL16
         we_n  <= addr_moves || (next_state != ST_WR_LOW); // see RL5 RL20
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rsp_valid    <= 1'b0;
         rsp_data     <= '0;
         poll_timeout <= 1'b0;
      end else begin
         rsp_valid <= (state == ST_RD) && cnt_done;
         if ((state == ST_RD) && cnt_done) begin
            rsp_data <= data_sync;
         end
         if (take_idle) begin
            poll_timeout <= 1'b0;
         end else if (state == ST_POLL_GAP && wait_over &&
                      !(poll_match && ready_sync)) begin
            poll_timeout <= 1'b1;
         end
      end
   end

   assign mem_bus.chip_sel_n = sel_n;
   assign mem_bus.out_en_n   = oe_n;
   assign mem_bus.write_en_n = we_n;
   assign mem_bus.addr       = addr;
   assign mem_data_out       = wdata;
   // Drive data only in the write-low state, from a cycle before the pulse falls
   assign mem_data_oe_n      = !(state == ST_WR_LOW);   // see RL2

   // ==========================================================
   // Checks
   no_drive_read_a: assert property (@(posedge sys_clk) disable iff (reset)
      !oe_n |-> mem_data_oe_n && we_n)                  // see RL2
      else $error("bus contention during read");
   write_mode_a: assert property (@(posedge sys_clk) disable iff (reset)
      !we_n |-> !sel_n && oe_n)                         // see RL1
      else $error("write strobe outside write mode");
   pulse_width_a: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(we_n) |-> !we_n [*4])                       // see RL6
      else $error("write pulse too short");
   gap_width_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(we_n) |-> we_n [*5])                        // see RL22
      else $error("byte loads spaced too closely");
   read_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(oe_n) |-> !oe_n [*8])                       // see RL16
      else $error("read shorter than access time");
   page_limit_a: assert property (@(posedge sys_clk) disable iff (reset)
      page_cnt <= PAGE_C)                               // see RL7
      else $error("page overrun");
   same_page_a: assert property (@(posedge sys_clk) disable iff (reset)
      take_gap |-> req.addr[pew_pkg::ADDR_W-1:pew_pkg::COL_W] ==
         mem_bus.addr[pew_pkg::ADDR_W-1:pew_pkg::COL_W])  // see RL8
      else $error("page crossed in one load");
   poll_addr_a: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(oe_n) && busy |-> addr == last_addr)        // see RL17
      else $error("poll at wrong address");
   cov_read_c:  cover property (@(posedge sys_clk) rsp_valid);
   cov_page_c:  cover property (@(posedge sys_clk) take_gap);
   cov_done_c:  cover property (@(posedge sys_clk)
      state == ST_POLL_GAP && poll_match && ready_sync);
   cov_hold_c:  cover property (@(posedge sys_clk)
      state == ST_WR_LOW && cnt_done && !hold_done);
endmodule // pew_host

// file: rtl/pew_pkg.sv
// Package: constants and carrier types for the paged EEPROM host controller
package pew_pkg;
   // ==========================================================
   // Geometry
   localparam int ADDR_W     = 13;
   localparam int DATA_W     = 8;
   localparam int COL_W      = 6;
   localparam int PAGE_BYTES = 64;
   // ==========================================================
   // Timing, figures as printed and clock rate
   localparam int CLK_HZ       = 25_000_000;
   localparam int CLK_NS       = 40;
   localparam int WP_NS        = 150;    // Least write pulse
   localparam int NOISE_NS     = 20;     // Shorter pulses are noise
   localparam int BLC_MIN_NS   = 200;    // Least byte-load spacing
   localparam int BLC_MAX_US   = 200;    // Byte-load window close
   localparam int WC_MS        = 10;     // Internal write, longest
   localparam int ACC_NS       = 250;    // Read access
   localparam int WP_CYC  = (WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLC_MIN_CYC = (BLC_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLC_MAX_CYC = BLC_MAX_US * (CLK_HZ / 1_000_000);
   localparam int WC_CYC  = WC_MS * (CLK_HZ / 1_000);
   localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int CNT_W   = 20;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic              chip_sel_n;
      logic              out_en_n;
      logic              write_en_n;
      logic [ADDR_W-1:0] addr;
   } pew_bus_t;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pew_req_t;

   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_LAST
   } pew_op_t;
endpackage : pew_pkg

// file: rtl/pew_sync.sv
// Three-stage synchroniser with agreement of the last two stages
module pew_sync #(
   parameter int          W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               s1[i]   <= INIT[i];
               s2[i]   <= INIT[i];
               s3[i]   <= INIT[i];
               dout[i] <= INIT[i];
            end else begin
               s1[i] <= din[i];
               s2[i] <= s1[i];
               s3[i] <= s2[i];
               if (s2[i] == s3[i]) begin
                  dout[i] <= s3[i];
               end
            end
         end
      end
   endgenerate
endmodule // pew_sync

// file: tb/paged_eeprom_write_control_tb.sv
// Self-checking bench for the paged EEPROM host controller
module paged_eeprom_write_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic              sys_clk = 0;
   logic              reset = 1;
   logic              req_valid = 0;
   logic              req_last = 0;
   logic              hang = 0;
   pew_pkg::pew_req_t req = '0;
   pew_pkg::pew_bus_t mem_bus;
   logic              req_ready, rsp_valid, busy, poll_timeout;
   logic              mem_data_oe_n, rdy;
   logic [7:0]        rsp_data, mem_data_out, dev_out;
   int                n_errors = 0;
   int                checked = 0;
   int                wlow = 0;
   wire  [7:0] dev_in = mem_data_oe_n ? ~mem_data_out : mem_data_out;
   pew_host #(.BLC_MAX_CYC(20), .WC_CYC(200)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .req_last(req_last),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy),
      .poll_timeout(poll_timeout), .mem_bus(mem_bus),
      .mem_data_out(mem_data_out), .mem_data_oe_n(mem_data_oe_n),
      .mem_data_in(dev_out), .mem_ready_in(rdy));
   pew_dev #(.BLC(20), .WC(60)) u_mem (
      .sys_clk(sys_clk), .bus(mem_bus), .din(dev_in), .hang(hang),
      .dout(dev_out), .rdy(rdy));
   always #20 sys_clk = ~sys_clk;
   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic send(input logic w, input logic [12:0] a,
                       input logic [7:0] d, input logic l);
      tick(1);
      req_valid = 1;
      req = '{wr: w, addr: a, data: d};
      req_last = l;
      do @(posedge sys_clk); while (req_ready !== 1'b1);
      #1 req_valid = 0;
   endtask
   task automatic rd(input logic [12:0] a, input logic [7:0] exp);
      int n;
      send(0, a, 8'h00, 0);
      n = 0;
      while (rsp_valid !== 1'b1 && n++ < 20) tick(1);
      chk({7'h00, rsp_valid}, 8'h01);
      chk(rsp_data, exp);
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (busy !== 1'b0 && n++ < 2000) tick(1);
      chk({7'h00, busy}, 8'h00);
      chk({7'h00, poll_timeout}, 8'h00);
   endtask
   task automatic do_reset;
      reset = 1;
      tick(20);
      reset = 0;
      chk({mem_bus.chip_sel_n, mem_bus.out_en_n, mem_bus.write_en_n,
           mem_data_oe_n, req_ready, rsp_valid, 2'b00}, 8'hf0);
   endtask
   // ==========================================================
   // Pin monitors
   always @(posedge sys_clk) if (!reset) begin
      if (!mem_bus.write_en_n) wlow++;
      else begin
         if (wlow > 0 && wlow < pew_pkg::WP_CYC) chk(8'h01, 8'h00);
         wlow = 0;
      end
      if (!mem_bus.write_en_n && !mem_bus.out_en_n) chk(8'h02, 8'h00);
      if (!mem_data_oe_n && !mem_bus.out_en_n) chk(8'h03, 8'h00);
   end
   // ==========================================================
   // Scenarios
   task automatic t_byte;
      rd(13'h0064, 8'hff);
      send(1, 13'h0064, 8'h5a, 1);
      tick(6);
      chk({busy, req_ready, rdy, 5'h00}, 8'h80);
      wait_done();
      rd(13'h0064, 8'h5a);
   endtask
   task automatic t_page;
      logic [5:0] cols [4];
      cols = '{6'h00, 6'h3f, 6'h11, 6'h05};
      for (int i = 0; i < 4; i++) begin
         // Slow requester ahead of the third byte
         if (i == 2) tick(30);
         send(1, {7'h12, cols[i]}, 8'hc0 + 8'(i), 1'(i == 3));
      end
      wait_done();
      for (int i = 0; i < 4; i++)
         rd({7'h12, cols[i]}, 8'hc0 + 8'(i));
   endtask
   task automatic t_cross;
      send(1, 13'h0043, 8'h11, 0);
      send(1, 13'h0083, 8'h22, 1);
      wait_done();
      rd(13'h0043, 8'h11);
      rd(13'h0083, 8'h22);
   endtask
   task automatic t_hang;
      int n;
      hang = 1;
      send(1, 13'h1fff, 8'h3c, 1);
      n = 0;
      while (poll_timeout !== 1'b1 && n++ < 400) tick(1);
      chk({7'h00, poll_timeout}, 8'h01);
      hang = 0;
      do_reset();
      tick(100);
      rd(13'h1fff, 8'h3c);
   endtask
   task automatic close_out;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      do_reset();
      t_byte();
      t_page();
      t_cross();
      t_hang();
      close_out();
   end
   initial begin
      #(20000 * 40);
      n_errors++;
      close_out();
   end
endmodule // paged_eeprom_write_control_tb

// file: tb/pew_dev.sv
// Behavioural paged EEPROM answering the host controller's pins
module pew_dev #(
   parameter int BLC = 20,
   parameter int WC  = 60
) (
   input  wire logic              sys_clk,
   input  wire pew_pkg::pew_bus_t bus,
   input  wire logic [7:0]        din,
   input  wire logic              hang,
   output logic      [7:0]        dout,
   output logic                   rdy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0]  mem [0:8191];
   logic [7:0]  pbuf [0:63];
   logic [63:0] pv = '0;
   logic [6:0]  row;
   logic [5:0]  col;
   logic [7:0]  dlat;
   logic [7:0]  last_d = 8'hff;
   logic        prev_on = 1'b1;
   logic        armed = 1'b0;
   logic        loading = 1'b0;
   logic        writing = 1'b0;
   int          cnt = 0;
   // Elevated enable level is never driven, so no bulk erase
   wire  wr_on = !bus.chip_sel_n && bus.out_en_n &&
                 !bus.write_en_n;
   wire  rd_on = !bus.chip_sel_n && !bus.out_en_n &&
                 bus.write_en_n;
   initial dout = 8'h00;
   initial for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
   // Open drain: released reads as the pull-up level
   assign rdy = !(loading || writing);
   // ==========================================================
   // Write control
   always @(posedge sys_clk) begin
      prev_on <= wr_on;
      if (wr_on) dlat <= din;
      // Lockout: a fall must be seen first
      if (wr_on && !prev_on && !writing) begin
         if (!loading) row <= bus.addr[12:6];
         col <= bus.addr[5:0];
         armed <= 1'b1;
         loading <= 1'b1;
      end
      if (!wr_on && prev_on && armed) begin
         pbuf[col] <= dlat;
         pv[col] <= 1'b1;
         last_d <= dlat;
         armed <= 1'b0;
      end
      if (loading && !writing) begin
         if (wr_on) cnt <= 0;
         else if (cnt == BLC) begin
            writing <= 1'b1;
            cnt <= 0;
         end else cnt <= cnt + 1;
      end
      if (writing && !hang) begin
         if (cnt == WC) begin
            for (int i = 0; i < 64; i++)
               if (pv[i]) mem[{row, 6'(i)}] <= pbuf[i];
            pv <= '0;
            writing <= 1'b0;
            loading <= 1'b0;
         end else cnt <= cnt + 1;
      end
      // Released lines toggle so stale data never matches
      dout <= !rd_on ? ~dout :
              rdy ? mem[bus.addr] : ~last_d;
   end
endmodule // pew_dev
